// File: inc/pcamc_pkg.sv
// Package of constants for the counter array mode control block
package pcamc_pkg;

   // ==========================================================
   // Register map (word offsets, one register per address)
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_COUNT = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
   localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;
   localparam logic [3:0] ADDR_CONTROL = 4'h5;

   // ==========================================================
   // Mode register fields
   localparam int MODE_IDLE_HOLD_BIT = 7;
   localparam int MODE_WDOG_BIT = 6;
   localparam int MODE_SRC_HI = 2;
   localparam int MODE_SRC_LO = 1;
   localparam int MODE_OVF_IRQ_BIT = 0;
   localparam logic [7:0] MODE_IMPL_MASK = 8'hC7;
   localparam logic [7:0] MODE_RESET = 8'h00;

   // ==========================================================
   // Control register fields
   localparam int CTRL_RUN_BIT = 6;
   localparam int CTRL_OVF_BIT = 7;

   // ==========================================================
   // Count sources
   localparam logic [1:0] SRC_DIV12 = 2'h0;
   localparam logic [1:0] SRC_DIV4 = 2'h1;
   localparam logic [1:0] SRC_T0OVF = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h3;
   localparam logic [3:0] DIV12_LAST = 4'hB;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam int EXT_MIN_PERIOD = 8;

   // ==========================================================
   // Status bits
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_EXT_FAST_BIT = 1;
   localparam int STAT_W = 2;
endpackage

// File: src/pcamc_top.sv
// Counter array mode control with timebase, register slave and interrupts
`timescale 1ns/1ns
module pcamc_top (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Avalon-MM slave
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Device inputs
   input wire logic IDLE_MODE,
   input wire logic TIMER0_OVF,
   input wire logic EXTERNAL_COUNT_INPUT,
   // Device outputs
   output logic MODULE4_WATCHDOG_EN,
   output logic [15:0] COUNT_VALUE,
   output logic COUNT_PULSE,
   output logic OVF_IRQ_REQ,
   output logic IRQ
);

   // ==========================================================
   // Input synchronisers (external count pin and idle input)
   logic ext_s1_r, ext_s2_r, ext_s3_r;
   logic idle_s1_r, idle_s2_r;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
         idle_s1_r <= 1'b0;
         idle_s2_r <= 1'b0;
      end else begin
         ext_s1_r <= EXTERNAL_COUNT_INPUT;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         idle_s1_r <= IDLE_MODE;
         idle_s2_r <= idle_s1_r;
      end
   end
   wire ext_rise = ext_s2_r & ~ext_s3_r;

   // ==========================================================
   // Registers and bus slave
   localparam int STAT_W_L = pcamc_pkg::STAT_W;
   logic [7:0] mode_r, mode_nxt;
   logic run_r, run_nxt;
   logic [STAT_W_L-1:0] stat_r, stat_nxt;
   logic [STAT_W_L-1:0] irq_en_r, irq_en_nxt;
   logic ack_r, ack_nxt;
   logic wait_r, wait_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic ovf_r, ovf_nxt;
   logic [3:0] div_r, div_nxt;
   logic [3:0] ext_gap_r, ext_gap_nxt;
   logic pulse_r, pulse_nxt;
   logic wd_r, wd_nxt;
   logic ovf_irq_r, ovf_irq_nxt;
   logic irq_r, irq_nxt;

   wire acc = (AVS_READ | AVS_WRITE) & ~ack_r;
   // Writes land only at the edge where waitrequest is seen low
   wire wr = AVS_WRITE & ack_r;
   wire [1:0] src = {mode_r[pcamc_pkg::MODE_SRC_HI], mode_r[pcamc_pkg::MODE_SRC_LO]};
   wire hold = mode_r[pcamc_pkg::MODE_IDLE_HOLD_BIT] & idle_s2_r;
   logic tick;
   logic ovf_event;
   logic ext_fast;

   always_comb begin
      mode_nxt = mode_r;
      run_nxt = run_r;
      irq_en_nxt = irq_en_r;
      ack_nxt = acc;
      wait_nxt = ~acc;
      rdata_nxt = rdata_r;
      cnt_nxt = cnt_r;
      ovf_nxt = ovf_r;
      div_nxt = div_r;
      ext_gap_nxt = ext_gap_r;
      stat_nxt = stat_r;
      tick = 1'b0;
      ext_fast = 1'b0;
      // Prescaler runs only while counting is allowed
      if (run_r && !hold) begin
         unique case (src)
            pcamc_pkg::SRC_DIV12: begin
               tick = (div_r == pcamc_pkg::DIV12_LAST);
               div_nxt = tick ? 4'h0 : div_r + 4'h1;
            end
            pcamc_pkg::SRC_DIV4: begin
               tick = (div_r[1:0] == pcamc_pkg::DIV4_LAST);
               div_nxt = tick ? 4'h0 : div_r + 4'h1;
            end
            pcamc_pkg::SRC_T0OVF: tick = TIMER0_OVF;
            pcamc_pkg::SRC_EXT: tick = ext_rise;
         endcase
      end
      // External pulses closer than osc/8 are flagged as an error while the external source is selected
      if (ext_rise) begin
         ext_fast = (src == pcamc_pkg::SRC_EXT) && (ext_gap_r != 4'h0);
         ext_gap_nxt = 4'(pcamc_pkg::EXT_MIN_PERIOD - 1);
      end else if (ext_gap_r != 4'h0) begin
         ext_gap_nxt = ext_gap_r - 4'h1;
      end
      ovf_event = tick && (cnt_r == 16'hFFFF);
      if (tick) begin
         cnt_nxt = cnt_r + 16'h0001;
      end
      if (wr && AVS_ADDRESS == pcamc_pkg::ADDR_MODE) begin
         mode_nxt = AVS_WRITEDATA[7:0] & pcamc_pkg::MODE_IMPL_MASK;
      end
      if (wr && AVS_ADDRESS == pcamc_pkg::ADDR_COUNT) begin
         cnt_nxt = AVS_WRITEDATA[15:0];
      end
      if (wr && AVS_ADDRESS == pcamc_pkg::ADDR_CONTROL) begin
         run_nxt = AVS_WRITEDATA[pcamc_pkg::CTRL_RUN_BIT];
         // Software may only clear the overflow flag
         if (!AVS_WRITEDATA[pcamc_pkg::CTRL_OVF_BIT]) begin
            ovf_nxt = 1'b0;
         end
      end
      if (wr && AVS_ADDRESS == pcamc_pkg::ADDR_IRQ_EN) begin
         irq_en_nxt = AVS_WRITEDATA[STAT_W_L-1:0];
      end
      if (wr && AVS_ADDRESS == pcamc_pkg::ADDR_IRQ_CLR) begin
         stat_nxt = stat_r & ~AVS_WRITEDATA[STAT_W_L-1:0];
      end
      // Set wins over a same-cycle clear
      if (ovf_event) begin
         ovf_nxt = 1'b1;
         stat_nxt[pcamc_pkg::STAT_OVF_BIT] = 1'b1;
      end
      if (ext_fast) begin
         stat_nxt[pcamc_pkg::STAT_EXT_FAST_BIT] = 1'b1;
      end
      if (AVS_READ && !ack_r) begin
         unique case (AVS_ADDRESS)
            pcamc_pkg::ADDR_MODE: rdata_nxt = {24'h00_0000, mode_r};
            pcamc_pkg::ADDR_COUNT: rdata_nxt = {16'h0000, cnt_r};
            pcamc_pkg::ADDR_STATUS: rdata_nxt = {30'h0000_0000, stat_r};
            pcamc_pkg::ADDR_IRQ_EN: rdata_nxt = {30'h0000_0000, irq_en_r};
            pcamc_pkg::ADDR_CONTROL:
               rdata_nxt = {24'h00_0000, ovf_r, run_r, 6'h00};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      pulse_nxt = tick;
      wd_nxt = mode_nxt[pcamc_pkg::MODE_WDOG_BIT];
      ovf_irq_nxt = ovf_nxt & mode_nxt[pcamc_pkg::MODE_OVF_IRQ_BIT];
      irq_nxt = |(stat_nxt & irq_en_nxt);
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         mode_r <= pcamc_pkg::MODE_RESET;
         run_r <= 1'b0;
         irq_en_r <= '0;
         stat_r <= '0;
         ack_r <= 1'b0;
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
         cnt_r <= 16'h0000;
         ovf_r <= 1'b0;
         div_r <= 4'h0;
         ext_gap_r <= 4'h0;
         pulse_r <= 1'b0;
         wd_r <= 1'b0;
         ovf_irq_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         run_r <= run_nxt;
         irq_en_r <= irq_en_nxt;
         stat_r <= stat_nxt;
         ack_r <= ack_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         cnt_r <= cnt_nxt;
         ovf_r <= ovf_nxt;
         div_r <= div_nxt;
         ext_gap_r <= ext_gap_nxt;
         pulse_r <= pulse_nxt;
         wd_r <= wd_nxt;
         ovf_irq_r <= ovf_irq_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Waitrequest is high until the single ack cycle
   assign AVS_WAITREQUEST = wait_r;
   assign AVS_READDATA = rdata_r;
   assign MODULE4_WATCHDOG_EN = wd_r;
   assign COUNT_VALUE = cnt_r;
   assign COUNT_PULSE = pulse_r;
   assign OVF_IRQ_REQ = ovf_irq_r;
   assign IRQ = irq_r;

   // ==========================================================
   // Checks
   chk_idle_hold: assert property (@(posedge REF_CLK) disable iff (RST)
      hold |-> !tick)
      else $error("count advanced while held in idle");

   chk_hold_div: assert property (@(posedge REF_CLK) disable iff (RST)
      hold |=> $stable(div_r))
      else $error("prescaler moved while held in idle");

   chk_wdog_follow: assert property (@(posedge REF_CLK) disable iff (RST)
      ##1 wd_r == mode_r[pcamc_pkg::MODE_WDOG_BIT])
      else $error("watchdog enable does not follow mode bit");

   chk_wdog_pin: assert property (@(posedge REF_CLK) disable iff (RST)
      MODULE4_WATCHDOG_EN == mode_r[pcamc_pkg::MODE_WDOG_BIT])
      else $error("watchdog pin differs from mode bit");

   // Mode may switch mid-period, so only a same-source tick is counted
   chk_div12_rate: assert property (@(posedge REF_CLK) disable iff (RST)
      (tick && src == pcamc_pkg::SRC_DIV12 && !wr)
      |=> !(tick && src == pcamc_pkg::SRC_DIV12) [*8])
      else $error("divide by twelve ticks too often");

   chk_div4_rate: assert property (@(posedge REF_CLK) disable iff (RST)
      (tick && src == pcamc_pkg::SRC_DIV4 && !wr)
      |=> !(tick && src == pcamc_pkg::SRC_DIV4) [*3])
      else $error("divide by four ticks too often");

   chk_t0_tick: assert property (@(posedge REF_CLK) disable iff (RST)
      (run_r && !hold && src == pcamc_pkg::SRC_T0OVF) |-> (tick == TIMER0_OVF))
      else $error("timer 0 overflow not counted");

   chk_ext_tick: assert property (@(posedge REF_CLK) disable iff (RST)
      (src == pcamc_pkg::SRC_EXT && tick) |-> $rose(ext_s2_r))
      else $error("external count without pin edge");

   chk_ext_fast: assert property (@(posedge REF_CLK) disable iff (RST)
      ext_fast |=> stat_r[pcamc_pkg::STAT_EXT_FAST_BIT])
      else $error("fast external pulse not flagged");

   chk_ovf_irq: assert property (@(posedge REF_CLK) disable iff (RST)
      (ovf_r && !mode_r[pcamc_pkg::MODE_OVF_IRQ_BIT]) |-> !OVF_IRQ_REQ ##0 1)
      else $error("overflow request while disabled");

   chk_ovf_req_on: assert property (@(posedge REF_CLK) disable iff (RST)
      (ovf_r && mode_r[pcamc_pkg::MODE_OVF_IRQ_BIT]) |-> OVF_IRQ_REQ)
      else $error("overflow request missing while enabled");

   chk_irq_level: assert property (@(posedge REF_CLK) disable iff (RST)
      IRQ == |(stat_r & irq_en_r))
      else $error("interrupt line differs from enabled status");

   chk_ovf_sticky: assert property (@(posedge REF_CLK) disable iff (RST)
      (stat_r[pcamc_pkg::STAT_OVF_BIT] && !(wr && AVS_ADDRESS == pcamc_pkg::ADDR_IRQ_CLR))
      |=> stat_r[pcamc_pkg::STAT_OVF_BIT])
      else $error("overflow status lost without clear");

   chk_reserved_zero: assert property (@(posedge REF_CLK) disable iff (RST)
      (mode_r & ~pcamc_pkg::MODE_IMPL_MASK) == 8'h00)
      else $error("reserved mode bits set");

   chk_wrap_flag: assert property (@(posedge REF_CLK) disable iff (RST)
      (tick && cnt_r == 16'hFFFF) |=> (ovf_r && cnt_r == 16'h0000))
      else $error("wrap did not set overflow flag");

   chk_run_gate: assert property (@(posedge REF_CLK) disable iff (RST)
      !run_r |-> !tick)
      else $error("count advanced while stopped");

   chk_count_step: assert property (@(posedge REF_CLK) disable iff (RST)
      (tick && !wr) |=> COUNT_VALUE == $past(cnt_r) + 16'h0001)
      else $error("count did not step by one");

   chk_count_hold: assert property (@(posedge REF_CLK) disable iff (RST)
      (!tick && !wr) |=> $stable(cnt_r))
      else $error("count moved without a pulse");

   chk_pulse_follow: assert property (@(posedge REF_CLK) disable iff (RST)
      tick |=> COUNT_PULSE)
      else $error("count pulse missing after increment");

   // Bus slave answers once per request, then drops the answer
   chk_wait_one: assert property (@(posedge REF_CLK) disable iff (RST)
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");

   chk_req_ack: assert property (@(posedge REF_CLK) disable iff (RST)
      ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
      else $error("request not answered in one cycle");
endmodule

// File: testbench/pcamc_ext_src.sv
// Model of the external count pulse source
`timescale 1ns/1ns
module pcamc_ext_src (
   // Clock
   input wire logic clk,
   // Control
   input wire logic run,
   input wire logic [7:0] period,
   // Pin
   output logic ext_pin
);
   logic [7:0] cnt_r;
   // ==========================================================
   // Pulse train
   // Pin rests low outside bursts; period never below eight cycles
   always @(posedge clk) begin
      if (!run) begin
         cnt_r <= 8'h00;
         ext_pin <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
         ext_pin <= (cnt_r < {1'b0, period[7:1]});
      end
   end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the counter array mode control block
`timescale 1ns/1ns
module tb_top;
   // ==========================================================
   // Signals
   logic clk, rst, rd, wr, idle, t0, t0_en, ext_run, ext_pin, wq, wdog, cp, ovf, irq;
   logic [3:0] adr;
   logic [31:0] wdat, rdat;
   logic [15:0] cnt;
   int bad_count, samples_checked, cyc;
   pcamc_top u_pcamc_top (.REF_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
      .IDLE_MODE(idle), .TIMER0_OVF(t0), .EXTERNAL_COUNT_INPUT(ext_pin),
      .MODULE4_WATCHDOG_EN(wdog), .COUNT_VALUE(cnt), .COUNT_PULSE(cp),
      .OVF_IRQ_REQ(ovf), .IRQ(irq));
   pcamc_ext_src u_pcamc_ext_src (.clk(clk), .run(ext_run), .period(8'h08),
      .ext_pin(ext_pin));
   // ==========================================================
   // Clock, timer 0 pulses and timeout
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      t0 <= t0_en && (cyc % 5 == 0);
      if (cyc == 20000) begin
         bad_count++;
         close_out;
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Holds the request until waitrequest is sampled low, then lets two edges pass
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wq !== 1'b0 && n < 50);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 50) chk("bus wait", 32'h0000_0001, 32'h0000_0000);
      repeat (2) @(posedge clk);
   endtask
   task automatic wrt(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(nm, q, e);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_mode;
      wrt(4'h0, 32'h0000_00FF);
      rdc("mode", 4'h0, 32'h0000_00C7);
      chk("wdog on", wdog, 1'b1);
      wrt(4'h0, 32'h0000_0000);
      chk("wdog off", wdog, 1'b0);
      rdc("unmapped", 4'hF, 32'h0000_0000);
      $display("test mode done");
   endtask
   task automatic t_src;
      int gaps [4] = '{12, 4, 5, 8};
      int n;
      logic [15:0] c0;
      for (int s = 0; s < 4; s++) begin
         wrt(4'h0, 32'(s) << 1);
         n = 0;
         while (cp !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
         end
         c0 = cnt;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (cp !== 1'b1 && n < 100);
         chk("pulse gap", n, gaps[s]);
         chk("step", cnt, c0 + 16'h0001);
      end
      $display("test source done");
   endtask
   task automatic t_idle;
      logic [15:0] c0;
      idle <= 1'b1;
      wrt(4'h0, 32'h0000_0082);
      repeat (6) @(posedge clk);
      c0 = cnt;
      repeat (40) @(posedge clk);
      chk("held", cnt, c0);
      wrt(4'h0, 32'h0000_0002);
      c0 = cnt;
      repeat (40) @(posedge clk);
      chk("runs", cnt - c0, 16'h000A);
      idle <= 1'b0;
      $display("test idle done");
   endtask
   task automatic t_ovf;
      wrt(4'h3, 32'h0000_0001);
      wrt(4'h0, 32'h0000_0003);
      wrt(4'h1, 32'h0000_FFFE);
      repeat (16) @(posedge clk);
      chk("ovf req", ovf, 1'b1);
      chk("irq", irq, 1'b1);
      rdc("control", 4'h5, 32'h0000_00C0);
      rdc("status", 4'h2, 32'h0000_0001);
      wrt(4'h0, 32'h0000_0002);
      chk("ovf masked", ovf, 1'b0);
      wrt(4'h3, 32'h0000_0000);
      chk("irq masked", irq, 1'b0);
      wrt(4'h3, 32'h0000_0001);
      wrt(4'h4, 32'h0000_0001);
      chk("irq cleared", irq, 1'b0);
      rdc("status clr", 4'h2, 32'h0000_0000);
      wrt(4'h0, 32'h0000_0003);
      wrt(4'h5, 32'h0000_0040);
      chk("flag cleared", ovf, 1'b0);
      $display("test overflow done");
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      {rd, wr, idle, t0, t0_en, ext_run} = '0;
      adr = 4'h0;
      wdat = 32'h0000_0000;
      {bad_count, samples_checked, cyc} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t0_en <= 1'b1;
      ext_run <= 1'b1;
      @(posedge clk);
      t_mode;
      wrt(4'h5, 32'h0000_0040);
      t_src;
      t_idle;
      t_ovf;
      close_out;
   end
endmodule
